// ### core/sub_flag_alu.v
`timescale 1ns/1ps
// subtractor with the five arithmetic flags, byte or word wide
module sub_flag_alu (
  // operands
  input  wire [15:0] minuend,
  input  wire [15:0] subtrahend,
  input  wire        byte_mode,
  // result and flags
  output wire [15:0] diff,
  output wire        carry,
  output wire        zero,
  output wire        signed_range_flag,
  output wire        negative,
  output wire        half_byte_borrow_flag
);

  wire [16:0] word_sum;
  wire [8:0]  byte_sum;
  wire [7:0]  low7_sum;
  wire [4:0]  low3_sum;

  // add the complement plus one, so carry out is the inverted borrow
  assign word_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 17'h00001;
  assign byte_sum = {1'b0, minuend[7:0]} + {1'b0, ~subtrahend[7:0]} + 9'h001;
  assign low7_sum = {1'b0, minuend[6:0]} + {1'b0, ~subtrahend[6:0]} + 8'h01;
  assign low3_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;

  // byte results keep the upper byte of the minuend
  assign diff     = byte_mode ? {minuend[15:8], byte_sum[7:0]} : word_sum[15:0];
  assign carry    = byte_mode ? byte_sum[8] : word_sum[16];
  assign zero     = byte_mode ? (byte_sum[7:0] == 8'h00) : (word_sum[15:0] == 16'h0000);
  assign negative = byte_mode ? byte_sum[7] : word_sum[15];
  // overflow when carry into the sign differs from carry out
  assign signed_range_flag = byte_mode ? (byte_sum[8] ^ low7_sum[7]) :
                                         (word_sum[16] ^ word_sum[15] ^ minuend[15] ^
                                          ~subtrahend[15]) ;
  // digit borrow out of bit 3 (byte) or bit 7 (word), set on borrow
  // word mode: the low byte sum carries out of bit 7, so its inverse is that borrow
  assign half_byte_borrow_flag = byte_mode ? ~low3_sum[4] : ~byte_sum[8];

endmodule

// ### core/sub_unit_defs.vh
`ifndef SUB_UNIT_DEFS_VH
`define SUB_UNIT_DEFS_VH

// ----------------------------------------
// opcode prefixes
// ----------------------------------------
`define OPC_FILE_PREFIX   9'h16a
`define OPC_TEN_BIT_CONSTANT_PREFIX  9'h162
`define OPC_ARRAY_PREFIX  5'h0a
`define OPC_SHORT_LIT_TAG 2'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define FLD_WIDTH_BIT     14
`define FLD_DEST_SEL_BIT  13
`define FLD_BASE_LSB      15
`define FLD_DMODE_LSB     11
`define FLD_DREG_LSB      7
`define FLD_SMODE_LSB     4
`define FLD_TEN_BIT_CONSTANT_LSB     4
`define DEFAULT_WORK_IDX  4'h0

// ----------------------------------------
// addressing modes
// ----------------------------------------
`define AM_DIRECT         3'h0
`define AM_INDIRECT       3'h1
`define AM_POST_DEC       3'h2
`define AM_POST_INC       3'h3
`define AM_PRE_DEC        3'h4
`define AM_PRE_INC        3'h5

// ----------------------------------------
// status word bit positions and reset
// ----------------------------------------
`define SW_C_BIT          0
`define SW_Z_BIT          1
`define SW_OV_BIT         2
`define SW_N_BIT          3
`define SW_DC_BIT         8
`define SW_RESET          16'h0000
`define DEFAULT_WORK_REGISTER_RESET        16'h0000

`endif

// ### core/subtract_instruction_unit.v
`timescale 1ns/1ps
`include "sub_unit_defs.vh"
// executes the four plain subtract forms in a single cycle
module subtract_instruction_unit (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // instruction issue
  input  wire        instr_valid,
  input  wire [23:0] instr_word,
  output reg         exec_done,
  output reg         instr_unknown,
  // data memory read, same-cycle answer
  output wire        mem_rd_en,
  output wire [15:0] mem_rd_addr,
  input  wire [15:0] mem_rd_data,
  // data memory write, registered
  output reg         mem_wr_en,
  output reg  [15:0] mem_wr_addr,
  output reg  [15:0] mem_wr_data,
  output reg  [1:0]  mem_wr_be,
  // working register load and view
  input  wire        reg_load_en,
  input  wire [3:0]  reg_load_sel,
  input  wire [15:0] reg_load_data,
  input  wire [3:0]  reg_view_sel,
  output wire [15:0] reg_view_data,
  // status
  output reg  [15:0] status_word
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pointer step per access width
  function [15:0] ptr_step;
    input byte_op;
    begin
      ptr_step = byte_op ? 16'h0001 : 16'h0002;
    end
  endfunction

  // effective address, pre-modified where the mode asks
  function [15:0] eff_addr;
    input [2:0]  mode;
    input [15:0] ptr;
    input        byte_op;
    begin
      case (mode)
        `AM_PRE_DEC: eff_addr = ptr - ptr_step(byte_op);
        `AM_PRE_INC: eff_addr = ptr + ptr_step(byte_op);
        default:     eff_addr = ptr;
      endcase
    end
  endfunction

  // pointer value after the access
  function [15:0] next_ptr;
    input [2:0]  mode;
    input [15:0] ptr;
    input        byte_op;
    begin
      case (mode)
        `AM_POST_DEC, `AM_PRE_DEC: next_ptr = ptr - ptr_step(byte_op);
        `AM_POST_INC, `AM_PRE_INC: next_ptr = ptr + ptr_step(byte_op);
        default:                   next_ptr = ptr;
      endcase
    end
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  reg  [15:0] work_reg [0:15];

  wire        byte_op   = instr_word[`FLD_WIDTH_BIT];
  wire        dest_file = instr_word[`FLD_DEST_SEL_BIT];
  wire [12:0] file_addr = instr_word[12:0];
  wire [9:0]  ten_bit_constant  = instr_word[13:`FLD_TEN_BIT_CONSTANT_LSB];
  wire [4:0]  five_bit_constant = instr_word[4:0];
  wire [3:0]  single_work_reg   = instr_word[3:0];
  wire [3:0]  base_sel  = instr_word[18:`FLD_BASE_LSB];
  wire [2:0]  dest_mode = instr_word[13:`FLD_DMODE_LSB];
  wire [3:0]  dest_sel  = instr_word[10:`FLD_DREG_LSB];
  wire [2:0]  src_mode  = instr_word[6:`FLD_SMODE_LSB];
  wire [3:0]  src_sel   = instr_word[3:0];

  // form detection; destination modes 6 and 7 are not subtracts
  wire form_file  = instr_word[23:15] == `OPC_FILE_PREFIX;
  wire form_ten_bit_constant = instr_word[23:15] == `OPC_TEN_BIT_CONSTANT_PREFIX;
  wire form_array = instr_word[23:19] == `OPC_ARRAY_PREFIX;
  wire form_five_bit_constant  = form_array && (instr_word[6:5] == `OPC_SHORT_LIT_TAG);
  // source modes 4 and 5 share bit 6 with the short literal tag, so test both bits
  wire form_reg   = form_array && (instr_word[6:5] != `OPC_SHORT_LIT_TAG);
  wire dmode_ok   = dest_mode <= `AM_PRE_INC;
  wire known      = form_file || form_ten_bit_constant || ((form_five_bit_constant || form_reg) && dmode_ok);
  wire go         = instr_valid && known;

  // ----------------------------------------
  // operand fetch
  // ----------------------------------------
  wire [15:0] default_work_register = work_reg[`DEFAULT_WORK_IDX];
  wire [15:0] base_register   = work_reg[base_sel];
  wire [15:0] source_register = work_reg[src_sel];
  wire [15:0] dest_register   = work_reg[dest_sel];
  wire [15:0] lit_reg         = work_reg[single_work_reg];
  wire        src_indirect    = form_reg && (src_mode != `AM_DIRECT);
  wire [15:0] src_ea          = eff_addr(src_mode, source_register, byte_op);
  wire [15:0] dst_ea          = eff_addr(dest_mode, dest_register, byte_op);

  // one read port serves the file operand or an indirect source
  assign mem_rd_en   = instr_valid && (form_file || src_indirect);
  assign mem_rd_addr = form_file ? {3'b000, file_addr} : src_ea;

  // forward a write still in flight so back-to-back forms see it
  wire        fwd_hit = mem_wr_en && (mem_wr_addr[15:1] == mem_rd_addr[15:1]);
  wire [15:0] rd_word = {(fwd_hit && mem_wr_be[1]) ? mem_wr_data[15:8] : mem_rd_data[15:8],
                         (fwd_hit && mem_wr_be[0]) ? mem_wr_data[7:0]  : mem_rd_data[7:0]};
  // byte reads take the lane picked by the low address bit
  wire [15:0] mem_operand = byte_op ?
                            {8'h00, mem_rd_addr[0] ? rd_word[15:8] : rd_word[7:0]} : rd_word;

  reg [15:0] op_a;
  reg [15:0] op_b;

  // select minuend and subtrahend per form
  always @* begin
    op_a = base_register;
    op_b = source_register;
    if (form_file) begin
      op_a = mem_operand;
      op_b = default_work_register;
    end else if (form_ten_bit_constant) begin
      op_a = lit_reg;
      op_b = {6'h00, ten_bit_constant};
    end else if (form_five_bit_constant) begin
      op_b = {11'h000, five_bit_constant};
    end else if (src_indirect) begin
      op_b = mem_operand;
    end
  end

  wire [15:0] diff;
  wire        f_c;
  wire        f_z;
  wire        f_ov;
  wire        f_n;
  wire        f_dc;

  sub_flag_alu u_alu (
    .minuend               (op_a),
    .subtrahend            (op_b),
    .byte_mode             (byte_op),
    .diff                  (diff),
    .carry                 (f_c),
    .zero                  (f_z),
    .signed_range_flag     (f_ov),
    .negative              (f_n),
    .half_byte_borrow_flag (f_dc)
  );

  // ----------------------------------------
  // destination steering
  // ----------------------------------------
  reg        wr_reg;
  reg [3:0]  wr_reg_sel;
  reg        wr_mem;
  reg [15:0] wr_mem_addr;

  always @* begin
    wr_reg      = 1'b0;
    wr_reg_sel  = dest_sel;
    wr_mem      = 1'b0;
    wr_mem_addr = dst_ea;
    if (form_file) begin
      wr_reg      = !dest_file;
      wr_reg_sel  = `DEFAULT_WORK_IDX;
      wr_mem      = dest_file;
      wr_mem_addr = {3'b000, file_addr};
    end else if (form_ten_bit_constant) begin
      wr_reg      = 1'b1;
      wr_reg_sel  = single_work_reg;
    end else begin
      wr_reg      = dest_mode == `AM_DIRECT;
      wr_mem      = dest_mode != `AM_DIRECT;
    end
  end

  // old upper byte is kept on byte writes to a register
  wire [15:0] reg_wr_val = byte_op ? {work_reg[wr_reg_sel][15:8], diff[7:0]} : diff;

  // ----------------------------------------
  // working registers
  // ----------------------------------------
  integer i;

  // later assignments win: pointer steps, then the result itself
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 16; i = i + 1) begin
        work_reg[i] <= `DEFAULT_WORK_REGISTER_RESET;
      end
    end else begin
      if (reg_load_en) begin
        work_reg[reg_load_sel] <= reg_load_data;
      end
      if (go && src_indirect) begin
        work_reg[src_sel] <= next_ptr(src_mode, source_register, byte_op);
      end
      if (go && !form_file && !form_ten_bit_constant && wr_mem) begin
        work_reg[dest_sel] <= next_ptr(dest_mode, dest_register, byte_op);
      end
      if (go && wr_reg) begin
        work_reg[wr_reg_sel] <= reg_wr_val;
      end
    end
  end

  assign reg_view_data = work_reg[reg_view_sel];

  // ----------------------------------------
  // memory write, status and completion
  // ----------------------------------------
  // byte data is copied to both lanes; the enable picks one
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_wr_en     <= 1'b0;
      mem_wr_addr   <= 16'h0000;
      mem_wr_data   <= 16'h0000;
      mem_wr_be     <= 2'h0;
      status_word   <= `SW_RESET;
      exec_done     <= 1'b0;
      instr_unknown <= 1'b0;
    end else begin
      mem_wr_en     <= go && wr_mem;
      exec_done     <= go;
      instr_unknown <= instr_valid && !known;
      if (go && wr_mem) begin
        mem_wr_addr <= wr_mem_addr;
        mem_wr_data <= byte_op ? {diff[7:0], diff[7:0]} : diff;
        mem_wr_be   <= byte_op ? (wr_mem_addr[0] ? 2'h2 : 2'h1) : 2'h3;
      end
      if (go) begin
        status_word[`SW_C_BIT]  <= f_c;
        status_word[`SW_Z_BIT]  <= f_z;
        status_word[`SW_OV_BIT] <= f_ov;
        status_word[`SW_N_BIT]  <= f_n;
        status_word[`SW_DC_BIT] <= f_dc;
      end
    end
  end

endmodule

// ### verification/data_mem_model.sv
`timescale 1ns/1ps
// data memory beside the core: same-cycle read, lane write
module data_mem_model (
  // clock
  input  wire        ref_clk,
  // read and write
  input  wire        mem_rd_en,
  input  wire [15:0] mem_rd_addr,
  output wire [15:0] mem_rd_data,
  input  wire        mem_wr_en,
  input  wire [15:0] mem_wr_addr,
  input  wire [15:0] mem_wr_data,
  input  wire [1:0]  mem_wr_be
);
  reg [15:0] mem [0:32767];
  integer    i;
  // known fill so no read ever returns unknowns
  initial begin
    for (i = 0; i < 32768; i = i + 1)
      mem[i] = i[15:0] ^ 16'h5a3c;
  end
  // bus toggles when unread so stale data never looks valid
  assign mem_rd_data = mem_rd_en ? mem[mem_rd_addr[15:1]] : {16{ref_clk}} ^ 16'h3c3c;
  // each lane written on its own
  always @(posedge ref_clk) begin
    if (mem_wr_en && mem_wr_be[0])
      mem[mem_wr_addr[15:1]][7:0] <= mem_wr_data[7:0];
    if (mem_wr_en && mem_wr_be[1])
      mem[mem_wr_addr[15:1]][15:8] <= mem_wr_data[15:8];
  end
endmodule

// ### verification/sub_unit_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks for the subtract unit
// ----------------------------------------
module sub_unit_monitor (
  // clock and reset
  input wire        ref_clk,
  input wire        rstn,
  // issue, memory and status
  input wire        instr_valid,
  input wire [23:0] instr_word,
  input wire        exec_done,
  input wire        instr_unknown,
  input wire        mem_rd_en,
  input wire [15:0] mem_rd_addr,
  input wire        mem_wr_en,
  input wire [15:0] mem_wr_addr,
  input wire [1:0]  mem_wr_be,
  input wire [15:0] status_word
);
  // decode; destination modes 6 and 7 are refused
  wire is_file = instr_word[23:15] == 9'h16a;
  wire is_lit  = instr_word[23:15] == 9'h162;
  wire is_arr  = instr_word[23:19] == 5'h0a && instr_word[13:11] < 3'h6;
  wire take    = instr_valid && (is_file || is_lit || is_arr);
  wire no_wr   = is_lit || (is_file && !instr_word[13]) || (is_arr && instr_word[13:11] == 3'h0);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_done_after_take: assert property (take |=> exec_done && !instr_unknown)
    else $error("no done pulse");
  chk_refused_word: assert property (instr_valid && !take |=> instr_unknown && !exec_done)
    else $error("refusal wrong");
  chk_idle_quiet: assert property (!instr_valid |=> !exec_done && !instr_unknown && !mem_wr_en)
    else $error("pulse without issue");
  chk_file_read: assert property (instr_valid && is_file |-> mem_rd_en &&
    mem_rd_addr == {3'h0, instr_word[12:0]}) else $error("file read address");
  chk_file_write: assert property (take && is_file && instr_word[13] |=> mem_wr_en &&
    mem_wr_addr == {3'h0, $past(instr_word[12:0])}) else $error("file write address");
  chk_direct_no_wr: assert property (take && no_wr |=> !mem_wr_en)
    else $error("write on direct destination");
  chk_lit_no_read: assert property (instr_valid && is_lit |-> !mem_rd_en)
    else $error("read on literal form");
  chk_lane_width: assert property (take && !no_wr |=> mem_wr_en && mem_wr_be ==
    ($past(instr_word[14]) ? (mem_wr_addr[0] ? 2'b10 : 2'b01) : 2'b11)) else $error("lanes");
  chk_zero_flags: assert property (exec_done && status_word[1] |-> status_word == 16'h0003)
    else $error("flags on zero result");
  chk_status_hold: assert property (!take |=> $stable(status_word))
    else $error("status moved");
  // main scenarios reached
  cover property (take && is_file && instr_word[13]);
  cover property (take && is_arr && instr_word[14] && !no_wr);
  cover property (instr_valid && !take);
endmodule

bind subtract_instruction_unit sub_unit_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn),
  .instr_valid(instr_valid), .instr_word(instr_word), .exec_done(exec_done),
  .instr_unknown(instr_unknown), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
  .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_be(mem_wr_be),
  .status_word(status_word));

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         ref_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         instr_valid = 1'b0;
  reg  [23:0] instr_word = 24'h000000;
  reg         reg_load_en = 1'b0;
  reg  [3:0]  reg_load_sel = 4'h0;
  reg  [15:0] reg_load_data = 16'h0000;
  reg  [3:0]  reg_view_sel = 4'h0;
  wire        exec_done, instr_unknown, mem_rd_en, mem_wr_en;
  wire [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, reg_view_data, status_word;
  wire [1:0]  mem_wr_be;
  integer     n_mismatch = 0;
  integer     check_count = 0;
  integer     i, k;
  reg  [15:0] wr [0:15];
  reg  [15:0] em [0:32767];
  reg  [15:0] est;
  // first word zeroes w5, last two are refused
  reg  [191:0] tbl = {24'hb10405, 24'hb57fff, 24'hb50a04, 24'hb14230, 24'hb11084,
                      24'h501968, 24'h5030e1, 24'h000000};
  always #50 ref_clk = ~ref_clk;
  subtract_instruction_unit u_dut (.ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .exec_done(exec_done), .instr_unknown(instr_unknown),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_be(mem_wr_be), .reg_load_en(reg_load_en), .reg_load_sel(reg_load_sel),
    .reg_load_data(reg_load_data), .reg_view_sel(reg_view_sel),
    .reg_view_data(reg_view_data), .status_word(status_word));
  data_mem_model u_mem (.ref_clk(ref_clk), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_be(mem_wr_be));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function [15:0] step(input [2:0] m, input [15:0] p, input bt);
    step = (m == 3'h2 || m == 3'h4) ? p - (bt ? 16'h1 : 16'h2)
         : (m == 3'h3 || m == 3'h5) ? p + (bt ? 16'h1 : 16'h2) : p;
  endfunction
  function [15:0] rdm(input [15:0] a, input bt);
    rdm = !bt ? em[a[15:1]] : a[0] ? {8'h00, em[a[15:1]][15:8]} : {8'h00, em[a[15:1]][7:0]};
  endfunction
  task wrm(input [15:0] a, input bt, input [15:0] v);
    if (!bt) em[a[15:1]] = v;
    else if (a[0]) em[a[15:1]][15:8] = v[7:0];
    else em[a[15:1]][7:0] = v[7:0];
  endtask
  task wdst(input [3:0] d, input bt, input [15:0] r);
    wr[d] = bt ? {wr[d][15:8], r[7:0]} : r;
  endtask
  task calc(input [15:0] a, input [15:0] b, input bt, output [15:0] r);
    reg [15:0] x;
    begin
      x = a - b;
      r = bt ? {8'h00, x[7:0]} : x;
      est = 16'h0000;
      est[8] = bt ? a[3:0] < b[3:0] : a[7:0] < b[7:0];
      est[3] = bt ? x[7] : x[15];
      est[2] = (bt ? a[7] ^ b[7] : a[15] ^ b[15]) && (est[3] != (bt ? a[7] : a[15]));
      est[1] = r == 16'h0000;
      est[0] = bt ? a[7:0] >= b[7:0] : a >= b;
    end
  endtask
  // pointers are read before any step; source steps first so destination wins
  task model(input [23:0] w);
    reg [15:0] b, r, ps, pd;
    begin
      ps = wr[w[3:0]];
      pd = wr[w[10:7]];
      if (w[23:15] == 9'h16a) begin
        calc(rdm({3'h0, w[12:0]}, w[14]), wr[0], w[14], r);
        if (w[13]) wrm({3'h0, w[12:0]}, w[14], r);
        else wdst(4'h0, w[14], r);
      end else if (w[23:15] == 9'h162) begin
        calc(ps, w[14] ? {8'h00, w[11:4]} : {6'h00, w[13:4]}, w[14], r);
        wdst(w[3:0], w[14], r);
      end else begin
        if (w[6:5] == 2'b11) b = {11'h000, w[4:0]};
        else if (w[6:4] == 3'h0) b = ps;
        else b = rdm(w[6] ? step(w[6:4], ps, w[14]) : ps, w[14]);
        calc(wr[w[18:15]], b, w[14], r);
        if (w[6:5] != 2'b11) wr[w[3:0]] = step(w[6:4], ps, w[14]);
        if (w[13:11] == 3'h0) wr[w[10:7]] = w[14] ? {pd[15:8], r[7:0]} : r;
        else wrm(w[13] ? step(w[13:11], pd, w[14]) : pd, w[14], r);
        if (w[13:11] != 3'h0) wr[w[10:7]] = step(w[13:11], pd, w[14]);
      end
    end
  endtask
  function [23:0] rnd(input [1:0] f);
    reg [31:0] r;
    begin
      r = $urandom;
      r[23:20] = r[23:20] % 4'h6;
      r[27:24] = r[27:24] % 4'h6;
      case (f)
        2'd0: rnd = {9'h16a, r[14:0]};
        2'd1: rnd = {9'h162, r[14], r[14] ? {2'b00, r[11:4]} : r[13:4], r[3:0]};
        2'd2: rnd = {5'h0a, r[18:14], r[22:20], r[10:7], 2'b11, r[4:0]};
        default: rnd = {5'h0a, r[18:14], r[22:20], r[10:7], r[26:24], r[3:0]};
      endcase
    end
  endfunction
  // ----------------------------------------
  // drivers and comparison
  // ----------------------------------------
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task ld(input [3:0] s, input [15:0] v);
    begin
      reg_load_en = 1'b1;
      reg_load_sel = s;
      reg_load_data = v;
      wr[s] = v;
      @(negedge ref_clk);
      reg_load_en = 1'b0;
    end
  endtask
  task go(input [23:0] w, input ok);
    begin
      instr_valid = 1'b1;
      instr_word = w;
      if (ok) model(w);
      @(negedge ref_clk);
      chk("exec_done", {15'h0, ok}, {15'h0, exec_done});
      chk("instr_unknown", {15'h0, !ok}, {15'h0, instr_unknown});
    end
  endtask
  // settle one more edge so the registered memory write has landed
  task cmp_all;
    begin
      instr_valid = 1'b0;
      @(negedge ref_clk);
      chk("status_word", est, status_word);
      for (i = 0; i < 16; i = i + 1) begin
        reg_view_sel = i[3:0];
        @(negedge ref_clk);
        chk("reg_view_data", wr[i], reg_view_data);
      end
      for (i = 0; i < 32768; i = i + 1)
        chk("memory", em[i], u_mem.mem[i]);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    k = $urandom(76);
    est = 16'h0000;
    for (i = 0; i < 16; i = i + 1)
      wr[i] = 16'h0000;
    repeat (8) @(negedge ref_clk);
    // the memory model fills itself at time zero; mirror it once that is surely done
    for (i = 0; i < 32768; i = i + 1)
      em[i] = u_mem.mem[i];
    rstn = 1'b1;
    cmp_all;
    for (k = 0; k < 16; k = k + 1)
      ld(k[3:0], $urandom & 16'hfffe);
    ld(4'h5, 16'h0040);
    for (k = 7; k >= 0; k = k - 1)
      go(tbl[24 * k +: 24], k > 1);
    cmp_all;
    repeat (25) begin
      for (k = 0; k < 16; k = k + 1)
        ld(k[3:0], $urandom & 16'hfffe);
      repeat (8) go(rnd($urandom), 1'b1);
      cmp_all;
    end
    rstn = 1'b0;
    est = 16'h0000;
    for (i = 0; i < 16; i = i + 1)
      wr[i] = 16'h0000;
    @(negedge ref_clk);
    rstn = 1'b1;
    cmp_all;
    summarize;
  end
endmodule
